// ---- rtl/ufn_pkg.sv ----
// Package for the USB frame number and endpoint interrupt enable slice.
// Assumes an AXI4-Lite register bus with 32-bit data on a 10 MHz clock.
package ufn_pkg;
	// Printed offsets are not all multiples of four: they are indices
	localparam logic [7:0]  IDX_FRAME_LO   = 8'hba;
	localparam logic [7:0]  IDX_FRAME_HI   = 8'hbb;
	localparam logic [7:0]  IDX_EP_IRQ_EN  = 8'hc2;
	localparam logic [7:0]  IDX_IRQ_STATUS = 8'hc4;
	localparam logic [7:0]  IDX_IRQ_CLEAR  = 8'hc5;
	localparam logic [7:0]  IDX_IRQ_ENABLE = 8'hc6;
	localparam logic [7:0]  IDX_EP_FLAGS   = 8'hc7;
	localparam int          ADDR_W         = 10;
	localparam int          NUM_EP         = 7;
	localparam int          FRAME_W        = 11;
	// Field positions in the high frame register
	localparam int          HI_CRC_GOOD_BIT = 5;
	localparam int          HI_CRC_BAD_BIT  = 4;
	// Interrupt status bit positions
	localparam int          IRQ_SOF_BIT    = 0;
	localparam int          IRQ_FRAME_CRC_BAD_BIT = 1;
	localparam int          IRQ_EP_BIT     = 2;
	localparam int          IRQ_W          = 3;
	// Reset values and AXI response codes
	localparam logic [7:0]  EP_EN_RESET    = 8'h00;
	localparam logic [10:0] FRAME_RESET    = 11'h000;
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;
	// Write-side slave states
	typedef enum logic [1:0]
	{
		UFN_W_IDLE = 2'b00,
		UFN_W_RESP = 2'b01
	} ufn_wstate_e;
endpackage : ufn_pkg

// ---- rtl/ufn_ep_irq.sv ----
// Per-endpoint interrupt flag and enable gate.
// Assumes source levels come from logic on the same clock.
`timescale 1ns/1ps
module ufn_ep_irq
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Endpoint sources
	input  wire logic transmit_complete,
	input  wire logic receive_bank0_full,
	input  wire logic receive_bank1_full,
	input  wire logic setup_received,
	input  wire logic stall_or_crc_fault,
	input  wire logic irq_en,
	// Results
	output logic      endpoint_irq_flag,
	output logic      gated_irq
);
	// Flag follows the OR of all sources, clears itself when all drop
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			endpoint_irq_flag <= 1'b0;
		else
			endpoint_irq_flag <= transmit_complete | receive_bank0_full |
				receive_bank1_full | setup_received | stall_or_crc_fault; // R11
	end

	// Only enabled endpoints reach the global interrupt
	assign gated_irq = endpoint_irq_flag & irq_en; // R12 R1

	AST_EP_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		transmit_complete |=> endpoint_irq_flag) // R11
		else $error("flag not set by transmit complete");
	AST_EP_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
		gated_irq |-> (endpoint_irq_flag && irq_en)) // R12
		else $error("gated irq without flag and enable");
endmodule : ufn_ep_irq

// ---- rtl/ufn_frame_regs.sv ----
// Frame number capture, endpoint interrupt enables and AXI4-Lite slave.
// Assumes the SIE front end delivers same-clock SOF strobes and sources.
//
// Function
// [R1] One enable bit per endpoint 0 to 6 sits at bits 0 to 6 and gates that endpoint.
// [R2] Bit 7 of the endpoint enable register is reserved and always reads zero.
// [R3] The good flag is set when a received frame number passes its CRC.
// [R4] The bad flag is set when a received frame number fails its CRC.
// [R5] Both CRC flags are refreshed on every frame start so they describe the last one.
// [R6] The frame start event rises on the token identifier, before the CRC result.
// [R7] The 11-bit frame number has its top 3 bits in bits 2 to 0 of the high register.
// [R8] The frame number is stored even when its CRC is bad.
// [R9] The low 8 frame bits sit in a read-only low register that ignores writes.
// [R10] The high register is read-only and bits 7, 6 and 3 read zero.
// [R11] An endpoint flag follows the OR of its five sources and clears when all drop.
// [R12] The global interrupt from an endpoint needs both its flag and its enable.
// [R13] Reset clears frame number and flags; all 11 bits load at once.
`timescale 1ns/1ps
module ufn_frame_regs
	import ufn_pkg::*;
(
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Frame start from the packet decoder
	input  wire logic                sof_pid_seen,
	input  wire logic                sof_done,
	input  wire logic                sof_crc_ok,
	input  wire logic [FRAME_W-1:0]  sof_frame,
	// Endpoint interrupt sources, one bit per endpoint
	input  wire logic [NUM_EP-1:0]   transmit_complete,
	input  wire logic [NUM_EP-1:0]   receive_bank0_full,
	input  wire logic [NUM_EP-1:0]   receive_bank1_full,
	input  wire logic [NUM_EP-1:0]   setup_received,
	input  wire logic [NUM_EP-1:0]   stall_or_crc_fault,
	// Status towards the controller
	output logic                     frame_start_event,
	output logic [NUM_EP-1:0]        endpoint_irq_flag,
	output logic                     usb_irq,
	output logic                     irq
);
	logic [FRAME_W-1:0] frame_count_r;
	logic               frame_crc_good_r;
	logic               frame_crc_bad_r;
	logic [NUM_EP-1:0]  ep_irq_en_r;
	logic [IRQ_W-1:0]   irq_status_r;
	logic [IRQ_W-1:0]   irq_enable_r;
	logic [NUM_EP-1:0]  ep_gated;
	logic [NUM_EP-1:0]  ep_flag_w;
	ufn_wstate_e        wstate_r;
	logic               aw_held_r;
	logic               w_held_r;
	logic [ADDR_W-1:0]  awaddr_r;
	logic [31:0]        wdata_r;
	logic [3:0]         wstrb_r;
	logic               wr_fire;
	logic [7:0]         wr_idx;
	logic [7:0]         rd_idx;
	logic [31:0]        rd_val;
	logic               rd_hit;
	logic [IRQ_W-1:0]   irq_events;
	logic [IRQ_W-1:0]   irq_clear;

	// One flag-and-gate cell per endpoint
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++)
		begin : g_ep
			ufn_ep_irq u_ep
			(
				.aclk               (aclk),
				.aresetn            (aresetn),
				.transmit_complete  (transmit_complete[g]),
				.receive_bank0_full (receive_bank0_full[g]),
				.receive_bank1_full (receive_bank1_full[g]),
				.setup_received     (setup_received[g]),
				.stall_or_crc_fault (stall_or_crc_fault[g]),
				.irq_en             (ep_irq_en_r[g]),
				.endpoint_irq_flag  (ep_flag_w[g]),
				.gated_irq          (ep_gated[g])
			);
		end
	endgenerate

	// Frame start event on the token identifier, not the CRC
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			frame_start_event <= 1'b0;
		else
			frame_start_event <= sof_pid_seen; // R6
	end

	// Whole frame number and both flags load together, bad CRC or not
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			frame_count_r    <= FRAME_RESET; // R13
			frame_crc_good_r <= 1'b0;
			frame_crc_bad_r  <= 1'b0;
		end
		else if (sof_done)
		begin
			frame_count_r    <= sof_frame; // R7 R8 R13
			frame_crc_good_r <= sof_crc_ok; // R3 R5
			frame_crc_bad_r  <= !sof_crc_ok; // R4 R5
		end
	end

	// Endpoint outputs registered; global line from gated flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			endpoint_irq_flag <= '0;
			usb_irq           <= 1'b0;
		end
		else
		begin
			endpoint_irq_flag <= ep_flag_w;
			usb_irq           <= |ep_gated; // R12
		end
	end

	// Write path: address and data taken in either order
	assign wr_fire = aw_held_r && w_held_r && (wstate_r == UFN_W_IDLE);
	assign wr_idx  = awaddr_r[ADDR_W-1:2];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			awaddr_r      <= '0;
			wdata_r       <= '0;
			wstrb_r       <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			wstate_r      <= UFN_W_IDLE;
		end
		else
		begin
			s_axi_awready <= !aw_held_r && !s_axi_awready && (wstate_r == UFN_W_IDLE);
			s_axi_wready  <= !w_held_r && !s_axi_wready && (wstate_r == UFN_W_IDLE);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r     <= 1'b1;
				awaddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r     <= 1'b1;
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			case (wstate_r)
				UFN_W_IDLE:
				begin
					if (wr_fire)
					begin
						aw_held_r     <= 1'b0;
						w_held_r      <= 1'b0;
						s_axi_awready <= 1'b0;
						s_axi_wready  <= 1'b0;
						s_axi_bvalid  <= 1'b1;
						// Read-only registers answer OKAY and keep their value
						s_axi_bresp   <= (wr_idx == IDX_FRAME_LO || wr_idx == IDX_FRAME_HI ||
							wr_idx == IDX_EP_IRQ_EN || wr_idx == IDX_IRQ_STATUS ||
							wr_idx == IDX_IRQ_CLEAR || wr_idx == IDX_IRQ_ENABLE ||
							wr_idx == IDX_EP_FLAGS) ? RESP_OKAY : RESP_SLVERR;
						wstate_r      <= UFN_W_RESP;
					end
				end
				UFN_W_RESP:
				begin
					s_axi_awready <= 1'b0;
					s_axi_wready  <= 1'b0;
					if (s_axi_bready)
					begin
						s_axi_bvalid <= 1'b0;
						wstate_r     <= UFN_W_IDLE;
					end
				end
				default: wstate_r <= UFN_W_IDLE;
			endcase
		end
	end

	// Software-written enables; bit 7 never stored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ep_irq_en_r  <= EP_EN_RESET[NUM_EP-1:0];
			irq_enable_r <= '0;
		end
		else if (wr_fire && wstrb_r[0])
		begin
			if (wr_idx == IDX_EP_IRQ_EN)
				ep_irq_en_r <= wdata_r[NUM_EP-1:0]; // R1 R2
			if (wr_idx == IDX_IRQ_ENABLE)
				irq_enable_r <= wdata_r[IRQ_W-1:0];
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	assign irq_events = {|ep_gated, sof_done & !sof_crc_ok, sof_pid_seen};
	assign irq_clear  = (wr_fire && wstrb_r[0] && wr_idx == IDX_IRQ_CLEAR) ?
		wdata_r[IRQ_W-1:0] : '0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_status_r <= '0;
			irq <= 1'b0;
		end
		else
		begin
			irq_status_r <= (irq_status_r & ~irq_clear) | irq_events;
			irq <= |(((irq_status_r & ~irq_clear) | irq_events) & irq_enable_r);
		end
	end

	// Read decode; reserved bits read zero
	assign rd_idx = s_axi_araddr[ADDR_W-1:2];

	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		case (rd_idx)
			IDX_FRAME_LO:   rd_val[7:0] = frame_count_r[7:0]; // R9
			IDX_FRAME_HI:   rd_val[7:0] = {2'b00, frame_crc_good_r, frame_crc_bad_r, 1'b0,
				frame_count_r[10:8]}; // R7 R10
			IDX_EP_IRQ_EN:  rd_val[7:0] = {1'b0, ep_irq_en_r}; // R2
			IDX_IRQ_STATUS: rd_val[IRQ_W-1:0] = irq_status_r;
			IDX_IRQ_CLEAR:  rd_val = 32'h0000_0000;
			IDX_IRQ_ENABLE: rd_val[IRQ_W-1:0] = irq_enable_r;
			IDX_EP_FLAGS:   rd_val[NUM_EP-1:0] = endpoint_irq_flag;
			default:        rd_hit = 1'b0;
		endcase
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_val;
				s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	AST_SOF_FAST: assert property (@(posedge aclk) disable iff (!aresetn)
		sof_pid_seen |=> frame_start_event) // R6
		else $error("frame start event late");
	AST_CRC_GOOD: assert property (@(posedge aclk) disable iff (!aresetn)
		(sof_done && sof_crc_ok) |=> (frame_crc_good_r && !frame_crc_bad_r)) // R3
		else $error("good flag not set");
	AST_CRC_BAD: assert property (@(posedge aclk) disable iff (!aresetn)
		(sof_done && !sof_crc_ok) |=> (frame_crc_bad_r && !frame_crc_good_r)) // R4
		else $error("bad flag not set");
	AST_FLAGS_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		!sof_done |=> ($stable(frame_crc_good_r) && $stable(frame_crc_bad_r))) // R5
		else $error("flags moved without a frame");
	AST_FRAME_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
		sof_done |=> (frame_count_r == $past(sof_frame))) // R7
		else $error("frame number not loaded");
	AST_FRAME_BAD_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
		(sof_done && !sof_crc_ok) |=> (frame_count_r == $past(sof_frame))) // R8
		else $error("frame number skipped on bad crc");
	AST_FRAME_RO: assert property (@(posedge aclk) disable iff (!aresetn)
		(!sof_done && wr_fire) |=> $stable(frame_count_r)) // R9
		else $error("write changed frame number");
	AST_HI_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && $past(rd_idx) == IDX_FRAME_HI && $rose(s_axi_rvalid))
		|-> (s_axi_rdata[7:6] == 2'b00 && !s_axi_rdata[3])) // R10
		else $error("high register reserved bits set");
	AST_EN_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
		($rose(s_axi_rvalid) && $past(rd_idx) == IDX_EP_IRQ_EN) |-> !s_axi_rdata[7]) // R2
		else $error("enable bit 7 reads one");
	AST_USB_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		usb_irq |-> $past(|(ep_flag_w & ep_irq_en_r))) // R12
		else $error("global irq without enabled flag");
	AST_RESET_CLR: assert property (@(posedge aclk)
		!aresetn |=> (frame_count_r == FRAME_RESET && !frame_crc_bad_r)) // R13
		else $error("reset did not clear frame state");
	// Event pulse must trace back to a token one cycle earlier
	AST_SOF_CAUSE: assert property (@(posedge aclk) disable iff (!aresetn)
		frame_start_event |-> $past(sof_pid_seen)) // R6
		else $error("frame start event without token");
	// A clear must never swallow an event of the same cycle
	AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
		(irq_events != '0) |=> ((irq_status_r & $past(irq_events)) == $past(irq_events)))
		else $error("status event lost to a clear");

	COV_SOF_GOOD: cover property (@(posedge aclk) disable iff (!aresetn)
		sof_done && sof_crc_ok);
	COV_SOF_BAD: cover property (@(posedge aclk) disable iff (!aresetn)
		sof_done && !sof_crc_ok);
	COV_USB_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) $rose(usb_irq));
	COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready);
endmodule : ufn_frame_regs

// ---- dv/ufn_sof_host.sv ----
// Host-side model that delivers Start of Frame tokens to the frame slice.
// Assumes the bench calls its tasks just after a rising edge of aclk.
`timescale 1ns/1ps
module ufn_sof_host
	import ufn_pkg::*;
(
	// Clock
	input  wire logic            aclk,
	// Frame start towards the slice
	output logic                 sof_pid_seen,
	output logic                 sof_done,
	output logic                 sof_crc_ok,
	output logic [FRAME_W-1:0]   sof_frame
);
	// Idle levels; the frame field carries junk outside a packet
	initial
	begin
		sof_pid_seen = 1'b0;
		sof_done     = 1'b0;
		sof_crc_ok   = 1'b0;
		sof_frame    = 11'h7ff;
	end

	// Token identifier, one cycle wide
	task automatic pid();
		@(posedge aclk);
		sof_pid_seen <= 1'b1;
		@(posedge aclk);
		sof_pid_seen <= 1'b0;
	endtask : pid

	// Frame field, then inverted so stale data never looks valid
	task automatic done(input logic [FRAME_W-1:0] f, input logic ok);
		@(posedge aclk);
		sof_done   <= 1'b1;
		sof_crc_ok <= ok;
		sof_frame  <= f;
		@(posedge aclk);
		sof_done   <= 1'b0;
		sof_crc_ok <= ~ok;
		sof_frame  <= ~f;
	endtask : done
endmodule : ufn_sof_host

// ---- dv/tb.sv ----
// Self-checking bench for the frame number and endpoint enable slice.
// Assumes the slice answers AXI4-Lite at byte address four times the index.
`timescale 1ns/1ps
module tb;
	import ufn_pkg::*;
	logic               aclk = 1'b0;
	logic               aresetn = 1'b0;
	logic [ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr;
	logic               s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0]        s_axi_wdata, s_axi_rdata, d;
	logic [3:0]         s_axi_wstrb;
	logic [1:0]         s_axi_bresp, s_axi_rresp, r;
	logic               sof_pid_seen, sof_done, sof_crc_ok, frame_start_event, usb_irq, irq;
	logic [FRAME_W-1:0] sof_frame;
	logic [NUM_EP-1:0]  transmit_complete, receive_bank0_full, receive_bank1_full;
	logic [NUM_EP-1:0]  setup_received, stall_or_crc_fault, endpoint_irq_flag, ef;
	logic [NUM_EP-1:0]  sv [5];
	logic [7:0]         rst_idx [6] = '{IDX_FRAME_LO, IDX_FRAME_HI, IDX_EP_IRQ_EN,
	                                    IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_EP_FLAGS};
	int                 n_mismatch = 0, compares = 0, seed = 32'h3b7d;
	int                 frame_m, good_m, bad_m, en_m, st_m, k, s, f, t;

	ufn_frame_regs ufn_frame_regs_i (.*);
	ufn_sof_host   ufn_sof_host_i (.*);

	// 10 MHz clock
	always #50 aclk = ~aclk;

	task automatic report_and_stop();
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Bounded wait; a hung bus ends the run
	task automatic tick();
		@(posedge aclk);
		if (++t > 200)
		begin
			chk("bus_wait", 1, 0);
			report_and_stop();
		end
	endtask : tick

	// Write: address and data offered together, each dropped when taken
	task automatic axw(input logic [7:0] idx, input logic [7:0] v);
		bit a, w;
		a = 0;
		w = 0;
		t = 0;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(a && w))
		begin
			tick();
			if (!a && s_axi_awready === 1'b1)
			begin
				a = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready === 1'b1)
			begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do tick(); while (s_axi_bvalid !== 1'b1);
		// Ready stays up, so a following call never flips it in one step
		r = s_axi_bresp;
	endtask : axw

	task automatic axr(input logic [7:0] idx);
		t = 0;
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do tick(); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do tick(); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axr

	task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
		axr(idx);
		chk(nm, e, d);
		chk("rresp", RESP_OKAY, r);
	endtask : rchk

	task automatic frame_chk();
		rchk("frame_lo", IDX_FRAME_LO, frame_m & 8'hff);
		rchk("frame_hi", IDX_FRAME_HI, (good_m << HI_CRC_GOOD_BIT) |
			(bad_m << HI_CRC_BAD_BIT) | (frame_m >> 8));
	endtask : frame_chk

	task automatic drive_src();
		{stall_or_crc_fault, setup_received, receive_bank1_full, receive_bank0_full,
			transmit_complete} <= {sv[4], sv[3], sv[2], sv[1], sv[0]};
	endtask : drive_src

	// Main sequence
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		foreach (sv[i]) sv[i] = '0;
		{stall_or_crc_fault, setup_received, receive_bank1_full, receive_bank0_full,
			transmit_complete} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		{frame_m, good_m, bad_m, en_m, st_m} = '0;
		foreach (rst_idx[i]) rchk("reset_value", rst_idx[i], 0);
		chk("outputs", 0, {frame_start_event, endpoint_irq_flag, usb_irq, irq});
		axr(8'h10);
		chk("unmapped_rdata", 0, d);
		chk("unmapped_rresp", RESP_SLVERR, r);
		axw(8'h10, 8'h55);
		chk("unmapped_bresp", RESP_SLVERR, r);
		// Frames with good and corrupted CRC, random frame numbers
		for (k = 0; k < 12; k++)
		begin
			f = $random(seed);
			s = (k < 2) ? k : $random(seed);
			ufn_sof_host_i.pid();
			@(posedge aclk);
			chk("sof_event", 1, frame_start_event);
			@(posedge aclk);
			chk("sof_event", 0, frame_start_event);
			frame_chk();
			ufn_sof_host_i.done(11'(f), s[0]);
			frame_m = f & 32'h7ff;
			good_m = s & 1;
			bad_m = good_m ^ 1;
			frame_chk();
		end
		// Read-only frame registers ignore writes
		axw(IDX_FRAME_LO, 8'($random(seed)));
		chk("ro_bresp", RESP_OKAY, r);
		axw(IDX_FRAME_HI, 8'($random(seed)) & 8'h37);
		frame_chk();
		// Endpoint sources against enables, each source and endpoint alone first
		for (k = 0; k < 60; k++)
		begin
			if (k % 7 == 0)
			begin
				en_m = $random(seed) & 8'h7f;
				axw(IDX_EP_IRQ_EN, 8'(en_m));
				rchk("ep_en", IDX_EP_IRQ_EN, en_m);
			end
			for (s = 0; s < 5; s++)
				sv[s] = (k >= 35) ? 7'($random(seed) & $random(seed)) :
					(s == k % 5) ? 7'(1 << (k / 5)) : 7'h00;
			if (k == 59)
				foreach (sv[i]) sv[i] = '0;
			drive_src();
			ef = sv[0] | sv[1] | sv[2] | sv[3] | sv[4];
			repeat (4) @(posedge aclk);
			chk("ep_flags", ef, endpoint_irq_flag);
			chk("usb_irq", |(ef & en_m[6:0]), usb_irq);
		end
		// Sticky status, mask and clear for each event
		axw(IDX_IRQ_CLEAR, 8'h07);
		for (k = 0; k < IRQ_W; k++)
		begin
			if (k < 2)
				ufn_sof_host_i.pid();
			if (k == 1)
				ufn_sof_host_i.done(11'h2a5, 1'b0);
			if (k == 2)
			begin
				axw(IDX_EP_IRQ_EN, 8'h01);
				sv[1] = 7'h01;
				drive_src();
				repeat (4) @(posedge aclk);
				sv[1] = 7'h00;
				drive_src();
			end
			st_m |= (k == 0) ? 1 : (k == 1) ? 3 : 4;
			repeat (4) @(posedge aclk);
			rchk("irq_status", IDX_IRQ_STATUS, st_m);
			chk("irq_masked", 0, irq);
			axw(IDX_IRQ_ENABLE, 8'(1 << k));
			repeat (3) @(posedge aclk);
			chk("irq_raised", 1, irq);
			axw(IDX_IRQ_CLEAR, 8'(1 << k));
			st_m &= ~(1 << k);
			repeat (3) @(posedge aclk);
			chk("irq_cleared", 0, irq);
			// Mask everything again so the next event starts unmasked-free
			axw(IDX_IRQ_ENABLE, 8'h00);
			rchk("irq_status", IDX_IRQ_STATUS, st_m);
		end
		// Reset in mid-run clears the frame capture
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		{frame_m, good_m, bad_m} = '0;
		frame_chk();
		rchk("ep_en", IDX_EP_IRQ_EN, 0);
		report_and_stop();
	end
endmodule : tb
